// ### verilog/rxpt_port.sv
// rxpt_port: receive pass-through stream port with drop and multicast monitors
//
// How it works
// - valid only on beats carrying data
// - start flag on first beat only
// - end flag on final beat only
// - empty counts unused low-order symbols
// - empty width is log2 symbols per beat
// - error output held at zero
// - size in beats shown on start beat
// - one-cycle pulse per dropped packet
// - drop on bad destination, type, transaction while pass-through is off
// - multicast symbol toggles the event level
`timescale 1ns/1ps
module rxpt_port
  import rxpt_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  // configuration and transport-layer side
  input  wire logic               passthru_en,
  input  wire logic               up_valid,
  output logic                    up_ready,
  input  wire logic               up_sop,
  input  wire logic               up_eop,
  input  wire logic [EMPTY_W-1:0] up_empty,
  input  wire logic [SIZE_W-1:0]  up_size,
  input  wire logic [DATA_W-1:0]  up_data,
  input  wire logic               hdr_dest_ok,
  input  wire logic               hdr_type_ok,
  input  wire logic               hdr_tid_ok,
  input  wire logic               mcast_symbol_seen,
  // stream to the user sink
  input  wire logic               rx_ready,
  output logic                    rx_valid,
  output logic                    rx_sop,
  output logic                    rx_eop,
  output logic [EMPTY_W-1:0]      rx_empty,
  output logic [SIZE_W-1:0]       rx_size,
  output logic [DATA_W-1:0]       rx_data,
  output logic                    rx_error,
  // monitors
  output logic                    rx_pkt_dropped,
  output logic                    mcast_event_rx
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               fwd;
    logic               valid;
    logic               sop;
    logic               eop;
    logic [EMPTY_W-1:0] empty;
    logic [SIZE_W-1:0]  size;
    logic [DATA_W-1:0]  data;
    logic               error;
    logic               dropped;
    logic               mcast;
  } rxpt_port_state_type;

  rxpt_port_state_type st_q;
  rxpt_port_state_type st_d;

  rxpt_buf_if buf_if ();

  logic take;
  logic hdr_bad;
  logic beat_fwd;

  rxpt_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .bus     (buf_if.buffer_end)
  );

  // ----------------------------------------------------------------
  // input side: forward, drop, or leave to the internal layers
  // ----------------------------------------------------------------
  assign up_ready = buf_if.w_ready;
  assign take     = up_valid && buf_if.w_ready;
  assign hdr_bad  = !(hdr_dest_ok && hdr_type_ok && hdr_tid_ok);
  // the routing choice is made on the start beat and held for the packet
  assign beat_fwd = up_sop ? passthru_en : st_q.fwd;

  assign buf_if.w_valid = take && beat_fwd;
  assign buf_if.w_data  = {up_sop, up_eop, up_empty, up_size, up_data};
  // pop while the sink shows ready, so the registered beat lands in the very
  // next cycle, one after the ready cycle; a later pop would fall outside that cycle
  assign buf_if.r_ready = rx_ready;

  always_comb
  begin
    st_d         = st_q;
    st_d.error   = ERROR_LEVEL;
    st_d.dropped = 1'h0;
    if (take && up_sop)
    begin
      st_d.fwd = passthru_en;
      // with the port enabled every packet goes out, so nothing is dropped
      st_d.dropped = !passthru_en && hdr_bad;
    end
    // ------------------------------------------------------------
    // output side
    // ------------------------------------------------------------
    st_d.valid = buf_if.r_ready && buf_if.r_valid;
    if (st_d.valid)
    begin
      st_d.sop   = buf_if.r_data[POS_SOP];
      st_d.eop   = buf_if.r_data[POS_EOP];
      st_d.empty = buf_if.r_data[POS_EMPTY +: EMPTY_W];
      st_d.size  = buf_if.r_data[POS_SIZE +: SIZE_W];
      st_d.data  = buf_if.r_data[POS_DATA +: DATA_W];
    end
    else
    begin
      // flags drop with valid so a stale start or end is never seen
      st_d.sop = 1'h0;
      st_d.eop = 1'h0;
    end
    if (mcast_symbol_seen)
    begin
      st_d.mcast = !st_q.mcast;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q       <= '0;
      st_q.mcast <= RST_MCAST_LEVEL;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign rx_valid       = st_q.valid;
  assign rx_sop         = st_q.sop;
  assign rx_eop         = st_q.eop;
  assign rx_empty       = st_q.empty;
  assign rx_size        = st_q.size;
  assign rx_data        = st_q.data;
  assign rx_error       = st_q.error;
  assign rx_pkt_dropped = st_q.dropped;
  assign mcast_event_rx = st_q.mcast;

endmodule

// ### verilog/rxpt_pkg.sv
// rxpt_pkg: constants and types shared by the receive pass-through stream port
package rxpt_pkg;

  // ----------------------------------------------------------------
  // stream geometry
  // ----------------------------------------------------------------
  localparam int DATA_W          = 64;
  localparam int SYMBOL_W        = 8;
  localparam int SYMBOLS_PER_BEAT = DATA_W / SYMBOL_W;
  localparam int EMPTY_W         = $clog2(SYMBOLS_PER_BEAT);
  localparam int SIZE_W          = 6;
  localparam int ACCEPT_LATENCY  = 1;

  // ----------------------------------------------------------------
  // buffer geometry and word layout (msb to lsb: sop, eop, empty, size, data)
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 4;
  localparam int WORD_W     = 2 + EMPTY_W + SIZE_W + DATA_W;
  localparam int POS_DATA   = 0;
  localparam int POS_SIZE   = DATA_W;
  localparam int POS_EMPTY  = DATA_W + SIZE_W;
  localparam int POS_EOP    = DATA_W + SIZE_W + EMPTY_W;
  localparam int POS_SOP    = DATA_W + SIZE_W + EMPTY_W + 1;

  // ----------------------------------------------------------------
  // reset values and fixed output levels
  // ----------------------------------------------------------------
  localparam logic RST_MCAST_LEVEL = 1'h0;
  localparam logic ERROR_LEVEL     = 1'h0;

  typedef logic [WORD_W-1:0] rxpt_word_type;

endpackage

// ### verilog/rxpt_buf_if.sv
// rxpt_buf_if: valid/ready carrier between the port logic and its buffer
`timescale 1ns/1ps
interface rxpt_buf_if
  import rxpt_pkg::*;
();
  logic          w_valid;
  logic          w_ready;
  rxpt_word_type w_data;
  logic          r_valid;
  logic          r_ready;
  rxpt_word_type r_data;

  modport buffer_end (input w_valid, input w_data, input r_ready,
                      output w_ready, output r_valid, output r_data);
  modport user_end   (output w_valid, output w_data, output r_ready,
                      input w_ready, input r_valid, input r_data);
endinterface

// ### verilog/rxpt_fifo.sv
// rxpt_fifo: small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rxpt_fifo
  import rxpt_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic      clk_sys,
  input  wire logic      rst_b,
  rxpt_buf_if.buffer_end bus
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            count;
    logic                        not_full;
  } rxpt_fifo_state_type;

  rxpt_fifo_state_type st_q;
  rxpt_fifo_state_type st_d;

  logic push;
  logic pop;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  // ready comes from a flop so the upstream never sees a combinational path
  assign bus.w_ready = st_q.not_full;
  assign bus.r_valid = (st_q.count != '0);
  assign bus.r_data  = st_q.mem[st_q.rd_ptr];
  assign push        = bus.w_valid && st_q.not_full;
  assign pop         = bus.r_ready && bus.r_valid;

  always_comb
  begin
    st_d = st_q;
    if (push)
    begin
      st_d.mem[st_q.wr_ptr] = bus.w_data[WIDTH-1:0];
      st_d.wr_ptr           = ptr_inc(st_q.wr_ptr);
    end
    if (pop)
    begin
      st_d.rd_ptr = ptr_inc(st_q.rd_ptr);
    end
    st_d.count    = st_q.count + CNT_W'(push) - CNT_W'(pop);
    st_d.not_full = (st_d.count != CNT_W'(DEPTH));
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q          <= '0;
      st_q.not_full <= 1'h1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

endmodule

// ### verification/rxpt_port_props.sv
// rxpt_port_props: assertions on the stream port pins
`timescale 1ns/1ps
module rxpt_port_props
  import rxpt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic passthru_en,
  input wire logic up_valid,
  input wire logic up_ready,
  input wire logic up_sop,
  input wire logic hdr_dest_ok,
  input wire logic hdr_type_ok,
  input wire logic hdr_tid_ok,
  input wire logic mcast_symbol_seen,
  input wire logic rx_ready,
  input wire logic rx_valid,
  input wire logic rx_sop,
  input wire logic rx_eop,
  input wire logic rx_error,
  input wire logic rx_pkt_dropped,
  input wire logic mcast_event_rx
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire bad_sop = up_valid && up_ready && up_sop && !passthru_en
                 && !(hdr_dest_ok && hdr_type_ok && hdr_tid_ok);

  err_zero_a: assert property (!rx_error)
    else $error("error flag raised");
  ready_first_a: assert property (rx_valid |-> $past(rx_ready))
    else $error("beat without prior ready");
  sop_qual_a: assert property (rx_sop |-> rx_valid)
    else $error("start flag off a beat");
  eop_qual_a: assert property (rx_eop |-> rx_valid)
    else $error("end flag off a beat");
  drop_once_a: assert property (rx_pkt_dropped |=> !rx_pkt_dropped)
    else $error("drop pulse too long");
  drop_cause_a: assert property (rx_pkt_dropped |-> $past(bad_sop))
    else $error("drop without cause");
  drop_made_a: assert property (bad_sop |=> rx_pkt_dropped)
    else $error("drop pulse missing");
  mcast_flip_a: assert property (mcast_event_rx ==
    ($past(mcast_event_rx) ^ $past(mcast_symbol_seen))) else $error("bad toggle");

  cover property (rx_valid && rx_sop);
  cover property (rx_pkt_dropped);
  cover property (!up_ready);
endmodule

bind rxpt_port rxpt_port_props i_props (.*);

// ### verification/rxpt_sink.sv
// rxpt_sink: user sink model for the receive stream
`timescale 1ns/1ps
module rxpt_sink
  import rxpt_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               stall,
  input  wire logic               slow,
  output logic                    rx_ready,
  input  wire logic               rx_valid,
  input  wire logic               rx_sop,
  input  wire logic               rx_eop,
  input  wire logic [EMPTY_W-1:0] rx_empty,
  input  wire logic [SIZE_W-1:0]  rx_size,
  input  wire logic [DATA_W-1:0]  rx_data
);
  rxpt_word_type q[$];
  logic          alt_q = 1'h0;
  logic          rdy_q = 1'h0;
  initial rx_ready = 1'h0;
  // slow mode offers ready every other cycle only
  always @(negedge clk_sys)
  begin
    alt_q    <= ~alt_q;
    rx_ready <= !stall && (!slow || alt_q);
  end
  // a beat counts only one cycle after ready
  always @(posedge clk_sys)
  begin
    rdy_q <= rx_ready;
    if (rx_valid && rdy_q)
      q.push_back({rx_sop, rx_eop, rx_eop ? rx_empty : 3'h0, rx_sop ? rx_size : 6'h00, rx_data});
  end
endmodule

// ### verification/tb_top.sv
// tb_top: self-checking bench for the receive pass-through stream port
`timescale 1ns/1ps
module tb_top
  import rxpt_pkg::*;
;
  logic clk_sys = 1'h0, rst_b = 1'h0, passthru_en = 1'h1, up_valid = 1'h0;
  logic up_sop = 1'h0, up_eop = 1'h0, hdr_dest_ok = 1'h1, hdr_type_ok = 1'h1;
  logic hdr_tid_ok = 1'h1, mcast_symbol_seen = 1'h0, stall = 1'h1, slow = 1'h0;
  logic [EMPTY_W-1:0] up_empty = 3'h5;
  logic [SIZE_W-1:0]  up_size = 6'h05;
  logic [DATA_W-1:0]  up_data = 64'h0;
  logic up_ready, rx_ready, rx_valid, rx_sop, rx_eop, rx_error, rx_pkt_dropped, mcast_event_rx;
  logic [EMPTY_W-1:0] rx_empty;
  logic [SIZE_W-1:0]  rx_size;
  logic [DATA_W-1:0]  rx_data;
  int num_errors = 0;
  int n_compared = 0;

  rxpt_port i_dut (.*);
  rxpt_sink i_sink (.*);

  always #12.5 clk_sys = ~clk_sys;

  task automatic conclude();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hang();
    num_errors++;
    conclude();
  endtask

  // request held until the edge that sees up_ready high
  task automatic send(input logic s, input logic e, input logic [DATA_W-1:0] d);
    int n;
    @(negedge clk_sys);
    {up_valid, up_sop, up_eop, up_data} = {1'h1, s, e, d};
    for (n = 0; n < 50 && up_ready !== 1'h1; n++)
      @(negedge clk_sys);
    if (n == 50)
      hang();
    @(posedge clk_sys);
  endtask

  task automatic wait_got(input int n);
    int t;
    for (t = 0; t < 200 && i_sink.q.size() < n; t++)
      @(negedge clk_sys);
    if (t == 200)
      hang();
  endtask

  task automatic fill_drain();
    int i;
    for (i = 0; i < 4; i++)
      send(i == 0, 1'h0, 64'hA0 + i);
    @(negedge clk_sys);
    up_valid = 1'h0;
    repeat (2) @(negedge clk_sys);
    cmp(up_ready, 1'h0);
    stall = 1'h0;
    slow = 1'h1;
    send(1'h0, 1'h1, 64'hA4);
    @(negedge clk_sys);
    up_valid = 1'h0;
    wait_got(5);
    cmp(i_sink.q.size(), 5);
    for (i = 0; i < 5; i++)
      cmp(i_sink.q[i], {i == 0, i == 4, i == 4 ? 3'h5 : 3'h0, i == 0 ? 6'h05 : 6'h00, 64'hA0 + i});
    i_sink.q.delete();
  endtask

  // one failing check each, then a clean packet, then pass-through on
  task automatic drops();
    int k, n, c;
    slow = 1'h0;
    for (k = 0; k < 5; k++)
    begin
      passthru_en = (k == 4);
      {hdr_dest_ok, hdr_type_ok, hdr_tid_ok} = (k == 4) ? 3'h0 : 3'h7 ^ (3'h1 << k);
      send(1'h1, 1'h1, 64'hD0 + k);
      c = 0;
      for (n = 0; n < 4; n++)
      begin
        @(negedge clk_sys);
        up_valid = 1'h0;
        c += rx_pkt_dropped;
      end
      cmp(c, k < 3);
    end
    wait_got(1);
    cmp(i_sink.q.size(), 1);
  endtask

  task automatic mcast();
    int k;
    logic lvl;
    lvl = mcast_event_rx;
    for (k = 0; k < 3; k++)
    begin
      @(negedge clk_sys);
      mcast_symbol_seen = 1'h1;
      @(negedge clk_sys);
      mcast_symbol_seen = 1'h0;
      cmp(mcast_event_rx ^ lvl, 1'h1);
      lvl = mcast_event_rx;
    end
    repeat (3) @(negedge clk_sys);
    cmp(mcast_event_rx, lvl);
  endtask

  initial
  begin
    repeat (12) @(negedge clk_sys);
    rst_b = 1'h1;
    @(negedge clk_sys);
    cmp({rx_valid, rx_sop, rx_eop, rx_error, rx_pkt_dropped, mcast_event_rx, up_ready}, 7'h01);
    fill_drain();
    drops();
    mcast();
    conclude();
  end
endmodule
